// ==== core/vrc_pkg.sv ====
package vrc_pkg;
    // register byte offsets on the bus
    localparam logic [11:0] LADDER_CTRL_OFS = 12'h000;
    localparam logic [11:0] BANDGAP_CTRL_OFS = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
    // ladder control fields
    localparam int LAD_CMP1_BIT = 7;
    localparam int LAD_CMP2_BIT = 6;
    localparam int LAD_RANGE_BIT = 5;
    localparam logic [7:0] LAD_WRITE_MASK = 8'hEF;
    localparam logic [7:0] LAD_RESET = 8'h00;
    // bandgap control fields
    localparam int BG_SETTLED_BIT = 5;
    localparam int BG_BYPASS_BIT = 4;
    localparam int BG_EN_BIT = 3;
    localparam int BG_FIXED_OE_BIT = 2;
    localparam int BG_LADDER_OE_BIT = 1;
    localparam logic [7:0] BG_WRITE_MASK = 8'h1E;
    localparam logic [7:0] BG_RESET = 8'h00;
    // interrupt status fields: settle rise, settle fall
    localparam int IRQ_SETTLE_BIT = 0;
    localparam int IRQ_UNSETTLE_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // pin source encoding
    typedef enum logic [1:0] {
        VRC_PIN_NONE = 2'b00,
        VRC_PIN_FIXED = 2'b01,
        VRC_PIN_LADDER = 2'b10
    } vrc_pin_src_t;
endpackage

// ==== core/vrc_top.sv ====
// Overview of operation
// - cmp1 route enable 1 powers ladder to cmp1 input; 0 gives bandgap reference
// - cmp2 route enable 1 powers ladder to cmp2 input; 0 gives bandgap reference
// - range select bit: 1 selects low range, 0 selects high range
// - low range: tap code 0..15 gives code times supply over 24
// - high range: quarter supply plus code times supply over 32
// - ladder powered down when both routes and ladder pin output are off
// - ladder off, code zero, low range: ladder output pulled to ground
// - bandgap settled flag is read only and mirrors reference stability
// - bypass bit 1 sends pin unbuffered and powers buffer down
// - bandgap enable bit turns fixed reference on, off draws no current
// - ladder pin output off: fixed output enable chooses pin or internal
// - ladder pin output on: ladder drives pin, fixed enable ignored
// - high-voltage variant holds bandgap enable at one always
// - every reset clears implemented bits; unimplemented bits read zero
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module vrc_top #(
    parameter bit HV_VARIANT = 1'b0
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BANDGAP_STABLE,
    output logic LADDER_POWER_EN,
    output logic LADDER_RANGE_LOW,
    output logic [3:0] LADDER_TAP_CODE,
    output logic LADDER_GROUND,
    output logic CMP1_REF_SEL_LADDER,
    output logic CMP2_REF_SEL_LADDER,
    output logic BANDGAP_REF_EN,
    output logic REF_BUFFER_POWER_EN,
    output logic REF_BUFFER_BYPASS,
    output logic [1:0] REF_PIN_SRC,
    output logic IRQ
);
    logic [7:0] ladder_reg;
    logic [7:0] bandgap_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    logic settled_reg;
    logic settled_prev_reg;
    logic [31:0] rdata_next;
    logic wr_en;
    logic addr_ok;
    logic bg_en_eff;
    logic ladder_on;
    logic [1:0] irq_set;

    // decode of the mapped word addresses
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == vrc_pkg::LADDER_CTRL_OFS) || (a == vrc_pkg::BANDGAP_CTRL_OFS)
            || (a == vrc_pkg::IRQ_STATUS_OFS) || (a == vrc_pkg::IRQ_MASK_OFS);
    endfunction

    // zero wait state slave, error on unmapped address
    assign addr_ok = addr_mapped(PADDR);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign wr_en = PSEL && PENABLE && PWRITE && addr_ok && PSTRB[0];

    // ladder control register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ladder_reg <= vrc_pkg::LAD_RESET;
        end else if (wr_en && PADDR == vrc_pkg::LADDER_CTRL_OFS) begin
            ladder_reg <= PWDATA[7:0] & vrc_pkg::LAD_WRITE_MASK;
        end
    end

    // bandgap control register, settled bit never stored from software
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bandgap_reg <= vrc_pkg::BG_RESET;
        end else if (wr_en && PADDR == vrc_pkg::BANDGAP_CTRL_OFS) begin
            bandgap_reg <= PWDATA[7:0] & vrc_pkg::BG_WRITE_MASK;
        end
    end

    // settled flag sampling and edge tracking
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            settled_reg <= 1'b0;
            settled_prev_reg <= 1'b0;
        end else begin
            settled_reg <= BANDGAP_STABLE && bg_en_eff;
            settled_prev_reg <= settled_reg;
        end
    end

    assign irq_set[vrc_pkg::IRQ_SETTLE_BIT] = settled_reg && !settled_prev_reg;
    assign irq_set[vrc_pkg::IRQ_UNSETTLE_BIT] = !settled_reg && settled_prev_reg;

    // sticky status, write one clears, set wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_status_reg <= vrc_pkg::IRQ_RESET;
        end else if (wr_en && PADDR == vrc_pkg::IRQ_STATUS_OFS) begin
            irq_status_reg <= (irq_status_reg & ~PWDATA[1:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    // interrupt mask
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_mask_reg <= vrc_pkg::IRQ_RESET;
        end else if (wr_en && PADDR == vrc_pkg::IRQ_MASK_OFS) begin
            irq_mask_reg <= PWDATA[1:0];
        end
    end

    assign IRQ = |(irq_status_reg & irq_mask_reg);

    // read mux, unimplemented bits zero
    always_comb begin
        rdata_next = 32'h00000000;
        case (PADDR)
            vrc_pkg::LADDER_CTRL_OFS: rdata_next[7:0] = ladder_reg;
            vrc_pkg::BANDGAP_CTRL_OFS: begin
                rdata_next[7:0] = bandgap_reg;
                rdata_next[vrc_pkg::BG_EN_BIT] = bg_en_eff;
                rdata_next[vrc_pkg::BG_SETTLED_BIT] = settled_reg;
            end
            vrc_pkg::IRQ_STATUS_OFS: rdata_next[1:0] = irq_status_reg;
            vrc_pkg::IRQ_MASK_OFS: rdata_next[1:0] = irq_mask_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    // read data register, loaded in the setup cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rdata_next;
        end
    end

    // ladder control outputs
    assign ladder_on = ladder_reg[vrc_pkg::LAD_CMP1_BIT] || ladder_reg[vrc_pkg::LAD_CMP2_BIT]
        || bandgap_reg[vrc_pkg::BG_LADDER_OE_BIT];
    assign LADDER_POWER_EN = ladder_on;
    assign CMP1_REF_SEL_LADDER = ladder_reg[vrc_pkg::LAD_CMP1_BIT];
    assign CMP2_REF_SEL_LADDER = ladder_reg[vrc_pkg::LAD_CMP2_BIT];
    assign LADDER_RANGE_LOW = ladder_reg[vrc_pkg::LAD_RANGE_BIT];
    assign LADDER_TAP_CODE = ladder_reg[3:0];
    assign LADDER_GROUND = !ladder_on && ladder_reg[3:0] == 4'h0
        && ladder_reg[vrc_pkg::LAD_RANGE_BIT];

    // bandgap and buffer outputs
    assign bg_en_eff = HV_VARIANT || bandgap_reg[vrc_pkg::BG_EN_BIT];
    assign BANDGAP_REF_EN = bg_en_eff;
    assign REF_BUFFER_BYPASS = bandgap_reg[vrc_pkg::BG_BYPASS_BIT];
    assign REF_BUFFER_POWER_EN = !bandgap_reg[vrc_pkg::BG_BYPASS_BIT]
        && (REF_PIN_SRC != vrc_pkg::VRC_PIN_NONE);

    // pin source priority: ladder over fixed
    always_comb begin
        if (bandgap_reg[vrc_pkg::BG_LADDER_OE_BIT]) begin
            REF_PIN_SRC = vrc_pkg::VRC_PIN_LADDER;
        end else if (bandgap_reg[vrc_pkg::BG_FIXED_OE_BIT]) begin
            REF_PIN_SRC = vrc_pkg::VRC_PIN_FIXED;
        end else begin
            REF_PIN_SRC = vrc_pkg::VRC_PIN_NONE;
        end
    end

    // checks
    a_ladder_power_down: assert property (@(posedge CLK) disable iff (RST)
        (!CMP1_REF_SEL_LADDER && !CMP2_REF_SEL_LADDER && REF_PIN_SRC != vrc_pkg::VRC_PIN_LADDER)
        |-> !LADDER_POWER_EN) else $error("ladder powered while unused");
    a_cmp1_route: assert property (@(posedge CLK) disable iff (RST)
        CMP1_REF_SEL_LADDER |-> LADDER_POWER_EN) else $error("cmp1 route without ladder");
    a_cmp2_route: assert property (@(posedge CLK) disable iff (RST)
        CMP2_REF_SEL_LADDER |-> LADDER_POWER_EN) else $error("cmp2 route without ladder");
    a_ground_mode: assert property (@(posedge CLK) disable iff (RST)
        LADDER_GROUND |-> (LADDER_RANGE_LOW && LADDER_TAP_CODE == 4'h0 && !LADDER_POWER_EN))
        else $error("ground mode in wrong state");
    a_pin_priority: assert property (@(posedge CLK) disable iff (RST)
        bandgap_reg[vrc_pkg::BG_LADDER_OE_BIT] |-> REF_PIN_SRC == vrc_pkg::VRC_PIN_LADDER)
        else $error("ladder pin output not honoured");
    a_fixed_pin: assert property (@(posedge CLK) disable iff (RST)
        (!bandgap_reg[vrc_pkg::BG_LADDER_OE_BIT] && bandgap_reg[vrc_pkg::BG_FIXED_OE_BIT])
        |-> REF_PIN_SRC == vrc_pkg::VRC_PIN_FIXED) else $error("fixed pin output missing");
    a_buffer_bypass: assert property (@(posedge CLK) disable iff (RST)
        REF_BUFFER_BYPASS |-> !REF_BUFFER_POWER_EN) else $error("buffer powered in bypass");
    a_settled_ro: assert property (@(posedge CLK) disable iff (RST)
        (wr_en && PADDR == vrc_pkg::BANDGAP_CTRL_OFS) |=> !bandgap_reg[vrc_pkg::BG_SETTLED_BIT])
        else $error("settled flag stored from write");
    a_hv_enable: assert property (@(posedge CLK) disable iff (RST)
        HV_VARIANT |-> BANDGAP_REF_EN) else $error("hv variant bandgap off");
    a_write_effect: assert property (@(posedge CLK) disable iff (RST)
        (wr_en && PADDR == vrc_pkg::LADDER_CTRL_OFS) |=> ladder_reg == ($past(PWDATA[7:0]) & 8'hEF))
        else $error("ladder write not applied");
    a_unimpl_zero: assert property (@(posedge CLK) disable iff (RST)
        !ladder_reg[4] && bandgap_reg[7:6] == 2'b00 && !bandgap_reg[0])
        else $error("unimplemented bit set");
    c_ladder_pin: cover property (@(posedge CLK) disable iff (RST)
        REF_PIN_SRC == vrc_pkg::VRC_PIN_LADDER);
    c_ground: cover property (@(posedge CLK) disable iff (RST) LADDER_GROUND);
    c_settle_irq: cover property (@(posedge CLK) disable iff (RST) IRQ);
    c_bypass_fixed: cover property (@(posedge CLK) disable iff (RST)
        REF_BUFFER_BYPASS && REF_PIN_SRC == vrc_pkg::VRC_PIN_FIXED);
    c_both_routes: cover property (@(posedge CLK) disable iff (RST)
        CMP1_REF_SEL_LADDER && CMP2_REF_SEL_LADDER);

    // cmp1 route output mirrors its enable
    a_cmp1_follow: assert property (@(posedge CLK) disable iff (RST)
        CMP1_REF_SEL_LADDER == ladder_reg[vrc_pkg::LAD_CMP1_BIT])
        else $error("cmp1 route not following enable");

    // cmp1 falls back to bandgap when route off
    a_cmp1_bandgap: assert property (@(posedge CLK) disable iff (RST)
        !ladder_reg[vrc_pkg::LAD_CMP1_BIT] |-> !CMP1_REF_SEL_LADDER)
        else $error("cmp1 not on bandgap");

    // cmp2 route output mirrors its enable
    a_cmp2_follow: assert property (@(posedge CLK) disable iff (RST)
        CMP2_REF_SEL_LADDER == ladder_reg[vrc_pkg::LAD_CMP2_BIT])
        else $error("cmp2 route not following enable");

    // cmp2 falls back to bandgap when route off
    a_cmp2_bandgap: assert property (@(posedge CLK) disable iff (RST)
        !ladder_reg[vrc_pkg::LAD_CMP2_BIT] |-> !CMP2_REF_SEL_LADDER)
        else $error("cmp2 not on bandgap");

    // range output mirrors the range bit
    a_range_follow: assert property (@(posedge CLK) disable iff (RST)
        LADDER_RANGE_LOW == ladder_reg[vrc_pkg::LAD_RANGE_BIT])
        else $error("range select not following bit");

    // range only moves on a ladder write
    a_range_hold: assert property (@(posedge CLK) disable iff (RST)
        !(wr_en && PADDR == vrc_pkg::LADDER_CTRL_OFS) |=> $stable(LADDER_RANGE_LOW))
        else $error("range moved without write");

    // tap code presented unchanged to the ladder
    a_tap_follow: assert property (@(posedge CLK) disable iff (RST)
        LADDER_TAP_CODE == ladder_reg[3:0])
        else $error("tap code not presented");

    // tap code only moves on a ladder write
    a_tap_hold: assert property (@(posedge CLK) disable iff (RST)
        !(wr_en && PADDR == vrc_pkg::LADDER_CTRL_OFS) |=> $stable(LADDER_TAP_CODE))
        else $error("tap code moved without write");

    // ladder powered whenever any user needs it
    a_ladder_power_on: assert property (@(posedge CLK) disable iff (RST)
        (CMP1_REF_SEL_LADDER || CMP2_REF_SEL_LADDER || REF_PIN_SRC == vrc_pkg::VRC_PIN_LADDER)
        |-> LADDER_POWER_EN) else $error("ladder unpowered while used");

    // ladder power is exactly the or of its users
    a_power_exact: assert property (@(posedge CLK) disable iff (RST)
        LADDER_POWER_EN == (ladder_reg[7] || ladder_reg[6] || bandgap_reg[1]))
        else $error("ladder power not the or of users");

    // ground mode entered when all conditions hold
    a_ground_entry: assert property (@(posedge CLK) disable iff (RST)
        (!LADDER_POWER_EN && LADDER_TAP_CODE == 4'h0 && LADDER_RANGE_LOW) |-> LADDER_GROUND)
        else $error("ground mode not entered");

    // no ground mode in the high range
    a_ground_high: assert property (@(posedge CLK) disable iff (RST)
        !LADDER_RANGE_LOW |-> !LADDER_GROUND)
        else $error("ground mode in high range");

    // no ground mode with a nonzero tap
    a_ground_tap: assert property (@(posedge CLK) disable iff (RST)
        LADDER_TAP_CODE != 4'h0 |-> !LADDER_GROUND)
        else $error("ground mode with nonzero tap");

    // settled flag rises one cycle after a stable enabled reference
    a_settled_set: assert property (@(posedge CLK) disable iff (RST)
        (BANDGAP_STABLE && bg_en_eff) |=> settled_reg)
        else $error("settled flag missed");

    // settled flag clears when reference unstable or off
    a_settled_clr: assert property (@(posedge CLK) disable iff (RST)
        !(BANDGAP_STABLE && bg_en_eff) |=> !settled_reg)
        else $error("settled flag stuck");

    // settled flag is what a bandgap read returns
    a_settled_read: assert property (@(posedge CLK) disable iff (RST)
        (PSEL && !PENABLE && !PWRITE && PADDR == vrc_pkg::BANDGAP_CTRL_OFS)
        |=> PRDATA[vrc_pkg::BG_SETTLED_BIT] == $past(settled_reg)) else $error("settled read wrong");

    // unused bandgap bits read zero
    a_bg_unused_read: assert property (@(posedge CLK) disable iff (RST)
        (PSEL && !PENABLE && !PWRITE && PADDR == vrc_pkg::BANDGAP_CTRL_OFS)
        |=> PRDATA[7:6] == 2'b00 && !PRDATA[0]) else $error("bandgap unused bits read set");

    // unused ladder bit reads zero
    a_lad_unused_read: assert property (@(posedge CLK) disable iff (RST)
        (PSEL && !PENABLE && !PWRITE && PADDR == vrc_pkg::LADDER_CTRL_OFS)
        |=> !PRDATA[4]) else $error("ladder unused bit read set");

    // upper read data always zero
    a_upper_zero: assert property (@(posedge CLK) disable iff (RST)
        PRDATA[31:8] == 24'h000000)
        else $error("upper read data set");

    // bypass output mirrors its bit
    a_bypass_follow: assert property (@(posedge CLK) disable iff (RST)
        REF_BUFFER_BYPASS == bandgap_reg[vrc_pkg::BG_BYPASS_BIT])
        else $error("bypass not following bit");

    // buffer powered when buffered output is driven
    a_buffer_on: assert property (@(posedge CLK) disable iff (RST)
        (!REF_BUFFER_BYPASS && REF_PIN_SRC != vrc_pkg::VRC_PIN_NONE) |-> REF_BUFFER_POWER_EN)
        else $error("buffer unpowered while buffering");

    // enable bit turns the bandgap on
    a_bg_enable_on: assert property (@(posedge CLK) disable iff (RST)
        bandgap_reg[vrc_pkg::BG_EN_BIT] |-> BANDGAP_REF_EN)
        else $error("bandgap not enabled");

    // bandgap off when not enabled on the normal variant
    a_bg_enable_off: assert property (@(posedge CLK) disable iff (RST)
        (!HV_VARIANT && !bandgap_reg[vrc_pkg::BG_EN_BIT]) |-> !BANDGAP_REF_EN)
        else $error("bandgap on while disabled");

    // fixed output enable ignored under ladder output
    a_fixed_ignored: assert property (@(posedge CLK) disable iff (RST)
        bandgap_reg[vrc_pkg::BG_LADDER_OE_BIT] |-> REF_PIN_SRC != vrc_pkg::VRC_PIN_FIXED)
        else $error("fixed output not ignored");

    // both output enables off keeps reference internal
    a_pin_internal: assert property (@(posedge CLK) disable iff (RST)
        (!bandgap_reg[1] && !bandgap_reg[2]) |-> REF_PIN_SRC == vrc_pkg::VRC_PIN_NONE)
        else $error("pin driven while internal");

    // pin source code always legal
    a_pin_legal: assert property (@(posedge CLK) disable iff (RST)
        REF_PIN_SRC != 2'b11)
        else $error("illegal pin source");

    // high-voltage variant reads enable as one
    a_hv_read: assert property (@(posedge CLK) disable iff (RST)
        (HV_VARIANT && PSEL && !PENABLE && !PWRITE && PADDR == vrc_pkg::BANDGAP_CTRL_OFS)
        |=> PRDATA[vrc_pkg::BG_EN_BIT]) else $error("hv enable reads zero");

    // bandgap write lands masked at the access edge
    a_bg_write: assert property (@(posedge CLK) disable iff (RST)
        (wr_en && PADDR == vrc_pkg::BANDGAP_CTRL_OFS)
        |=> bandgap_reg == ($past(PWDATA[7:0]) & 8'h1E)) else $error("bandgap write not applied");

    // ladder holds without a ladder write
    a_ladder_hold: assert property (@(posedge CLK) disable iff (RST)
        !(wr_en && PADDR == vrc_pkg::LADDER_CTRL_OFS) |=> $stable(ladder_reg))
        else $error("ladder changed without write");

    // disabled strobe leaves control registers alone
    a_strobe_off: assert property (@(posedge CLK) disable iff (RST)
        (PSEL && PENABLE && PWRITE && !PSTRB[0]) |=> $stable(ladder_reg) && $stable(bandgap_reg))
        else $error("write with strobe off applied");

    // unmapped write leaves control registers alone
    a_unmapped_write: assert property (@(posedge CLK) disable iff (RST)
        (PSEL && PENABLE && PWRITE && !addr_ok) |=> $stable(ladder_reg) && $stable(bandgap_reg))
        else $error("unmapped write applied");

    // mapped access never flags an error
    a_no_err: assert property (@(posedge CLK) disable iff (RST)
        (PSEL && PENABLE && addr_ok) |-> !PSLVERR)
        else $error("error on mapped access");

    // settle events are sticky even against a clear
    a_settle_sticky: assert property (@(posedge CLK) disable iff (RST)
        irq_set[vrc_pkg::IRQ_SETTLE_BIT] |=> irq_status_reg[vrc_pkg::IRQ_SETTLE_BIT])
        else $error("settle event lost");

    // unsettle events are sticky even against a clear
    a_unsettle_sticky: assert property (@(posedge CLK) disable iff (RST)
        irq_set[vrc_pkg::IRQ_UNSETTLE_BIT] |=> irq_status_reg[vrc_pkg::IRQ_UNSETTLE_BIT])
        else $error("unsettle event lost");

    // unmasked event raises the interrupt next cycle
    a_irq_raise: assert property (@(posedge CLK) disable iff (RST)
        (|(irq_set & irq_mask_reg) && !(wr_en && PADDR == vrc_pkg::IRQ_MASK_OFS)) |=> IRQ)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

// ==== testbench/vrc_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module vrc_top_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stable = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, irq_a;
    logic [31:0] prdata_hv;
    logic bgen_hv;
    logic pwr, rlow, gnd, c1, c2, bgen, bufpwr, byp, irq;
    logic [3:0] tap;
    logic [1:0] src;
    logic [13:0] outs;
    int n_errors = 0;
    int n_compared = 0;

    // all analog control outputs packed for one compare
    assign outs = {pwr, rlow, tap, gnd, c1, c2, bgen, bufpwr, byp, src};

    vrc_top #(.HV_VARIANT(1'b0)) vrc_top_inst (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .BANDGAP_STABLE(stable),
        .LADDER_POWER_EN(pwr), .LADDER_RANGE_LOW(rlow), .LADDER_TAP_CODE(tap),
        .LADDER_GROUND(gnd), .CMP1_REF_SEL_LADDER(c1), .CMP2_REF_SEL_LADDER(c2),
        .BANDGAP_REF_EN(bgen), .REF_BUFFER_POWER_EN(bufpwr),
        .REF_BUFFER_BYPASS(byp), .REF_PIN_SRC(src), .IRQ(irq)
    );

    // high-voltage variant sharing the same bus
    vrc_top #(.HV_VARIANT(1'b1)) vrc_top_hv_inst (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata_hv),
        .PREADY(), .PSLVERR(), .BANDGAP_STABLE(stable),
        .LADDER_POWER_EN(), .LADDER_RANGE_LOW(), .LADDER_TAP_CODE(),
        .LADDER_GROUND(), .CMP1_REF_SEL_LADDER(), .CMP2_REF_SEL_LADDER(),
        .BANDGAP_REF_EN(bgen_hv), .REF_BUFFER_POWER_EN(),
        .REF_BUFFER_BYPASS(), .REF_PIN_SRC(), .IRQ()
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    task rc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(name, rd, exp);
    endtask

    // compare outputs once the write edge has settled
    task oc(input logic [13:0] exp);
        @(negedge clk);
        chk("outputs", {18'h0, outs}, {18'h0, exp});
    endtask

    localparam logic [11:0] LAD = vrc_pkg::LADDER_CTRL_OFS;
    localparam logic [11:0] BG = vrc_pkg::BANDGAP_CTRL_OFS;
    localparam logic [11:0] STS = vrc_pkg::IRQ_STATUS_OFS;

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rc("ladder", LAD, 32'h0);
        rc("bandgap", BG, 32'h0);
        oc(14'h0000);
        chk("hv enable", {31'h0, bgen_hv}, 32'h1);
        chk("hv bandgap", prdata_hv, 32'h8);
        wr(LAD, 32'hFF);
        rc("ladder", LAD, 32'hEF);
        oc(14'h3F60);
        wr(LAD, 32'h45);
        oc(14'h2520);
        wr(LAD, 32'h80);
        oc(14'h2040);
        wr(LAD, 32'h05);
        oc(14'h0500);
        wr(LAD, 32'h20);
        oc(14'h1080);
        wr(BG, 32'h02);
        oc(14'h300A);
        wr(BG, 32'hFF);
        rc("bandgap", BG, 32'h1E);
        oc(14'h3016);
        wr(BG, 32'h0C);
        oc(14'h1099);
        wr(BG, 32'h08);
        oc(14'h1090);
        // settle flag rise and fall, with events
        @(posedge clk);
        stable <= 1'b1;
        repeat (3) @(posedge clk);
        rc("bandgap", BG, 32'h28);
        wr(BG, 32'h08);
        rc("bandgap", BG, 32'h28);
        rc("status", STS, 32'h1);
        stable <= 1'b0;
        repeat (3) @(posedge clk);
        rc("bandgap", BG, 32'h08);
        rc("status", STS, 32'h3);
        wr(vrc_pkg::IRQ_MASK_OFS, 32'h3);
        @(negedge clk);
        irq_a = irq;
        wr(vrc_pkg::IRQ_MASK_OFS, 32'h0);
        @(negedge clk);
        chk("irq unmasked", {31'h0, irq_a}, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(STS, 32'h3);
        rc("status", STS, 32'h0);
        chk("irq clear", {31'h0, irq}, 32'h0);
        // unmapped place and disabled strobe
        apb(1'b0, 12'h010, 32'h0, 4'hF);
        chk("unmapped data", rd, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h010, 32'hFF, 4'hF);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, LAD, 32'h0F, 4'h0);
        rc("ladder", LAD, 32'h20);
        // reset in mid-run
        wr(LAD, 32'hC3);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc("ladder", LAD, 32'h0);
        rc("bandgap", BG, 32'h0);
        oc(14'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
